// ---- tagpio_pkg.sv ----
// shared constants of the time-aware pin unit: register map, field layout,
// reset values and tick counts.
// assumes a 32-bit AHB-Lite register bus and two channels of 64 bytes each.
package tagpio_pkg;

    localparam int unsigned CH_NUM = 2;

    // byte offsets inside one channel's window
    localparam logic [5:0] OFS_CTRL = 6'h00;
    localparam logic [5:0] OFS_CMP_LO = 6'h04;
    localparam logic [5:0] OFS_CMP_HI = 6'h08;
    localparam logic [5:0] OFS_PIV_LO = 6'h0C;
    localparam logic [5:0] OFS_PIV_HI = 6'h10;
    localparam logic [5:0] OFS_TCV_LO = 6'h14;
    localparam logic [5:0] OFS_TCV_HI = 6'h18;
    localparam logic [5:0] OFS_ECC = 6'h1C;
    // haddr bit that picks the channel
    localparam int unsigned CH_SEL_BIT = 6;

    // channel_control field layout
    localparam int unsigned CTRL_W = 7;
    localparam int unsigned CTRL_EN = 0;
    localparam int unsigned CTRL_OUT = 1;
    localparam int unsigned CTRL_POL_LSB = 2;
    localparam int unsigned CTRL_PER = 4;
    localparam int unsigned CTRL_SRC_LSB = 5;
    localparam logic [6:0] CTRL_RESET = 7'h00;

    typedef enum logic [1:0] {
        TAGPIO_POL_RISE = 2'b00,
        TAGPIO_POL_FALL = 2'b01,
        TAGPIO_POL_BOTH = 2'b10,
        TAGPIO_POL_NONE = 2'b11
    } tagpio_pol_t;

    // timer_source_select value of the local always_running_timer
    localparam logic [1:0] SRC_ART = 2'b00;

    // tick counts
    localparam logic [1:0] QUAL_TICKS = 2'h3;
    localparam logic [1:0] PULSE_TICKS = 2'h2;
    localparam int unsigned MIN_INTERVAL = 3;

endpackage

// ---- tagpio_qual.sv ----
// pin input qualifier: two-stage synchroniser, then a new level is
// accepted only after it has held for a number of timer ticks.
// assumes the tick is a one-cycle enable in the hclk domain.
`timescale 1ns/1ps
module tagpio_qual (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic ce,
    input wire logic tick,
    input wire logic pin,
    output logic rise,
    output logic fall
);
    typedef struct packed {
        logic sync1;
        logic sync2;
        logic level;
        logic [1:0] cnt;
        logic rise;
        logic fall;
    } tagpio_qual_st_t;

    tagpio_qual_st_t s;
    tagpio_qual_st_t next_s;

    always_comb begin
        next_s = s;
        next_s.sync1 = pin;
        next_s.sync2 = s.sync1;
        next_s.rise = 1'b0;
        next_s.fall = 1'b0;
        if (s.sync2 == s.level) begin
            next_s.cnt = 2'h0;
        end else if (tick) begin
            if (s.cnt == tagpio_pkg::QUAL_TICKS - 2'h1) begin
                next_s.level = s.sync2;
                next_s.cnt = 2'h0;
                next_s.rise = s.sync2;
                next_s.fall = ~s.sync2;
            end else begin
                next_s.cnt = s.cnt + 2'h1;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s <= '0;
        end else if (ce) begin
            s <= next_s;
        end
    end

    assign rise = s.rise;
    assign fall = s.fall;

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    qual_hold_a: assert property ((rise || fall) |->
        $past(s.cnt) == tagpio_pkg::QUAL_TICKS - 2'h1 && $past(tick))
        else $error("edge accepted before the level held three ticks");
endmodule

// ---- tagpio_outgen.sv ----
// output event shaper: rising or falling pulse of a fixed tick length,
// or a single toggle, started by a one-cycle event.
// assumes events are at least three ticks apart so pulses never overlap.
`timescale 1ns/1ps
module tagpio_outgen (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic ce,
    input wire logic tick,
    input wire logic [1:0] polarity,
    input wire logic event_in,
    output logic level
);
    typedef struct packed {
        logic level;
        logic [1:0] pcnt;
    } tagpio_og_st_t;

    tagpio_og_st_t s;
    tagpio_og_st_t next_s;
    tagpio_pkg::tagpio_pol_t pol;

    assign pol = tagpio_pkg::tagpio_pol_t'(polarity);

    always_comb begin
        next_s = s;
        if (event_in) begin
            case (pol)
                tagpio_pkg::TAGPIO_POL_RISE: begin
                    next_s.level = 1'b1;
                    next_s.pcnt = tagpio_pkg::PULSE_TICKS;
                end
                tagpio_pkg::TAGPIO_POL_FALL: begin
                    next_s.level = 1'b0;
                    next_s.pcnt = tagpio_pkg::PULSE_TICKS;
                end
                tagpio_pkg::TAGPIO_POL_BOTH: begin
                    next_s.level = ~s.level;
                end
                default: begin
                    next_s.level = s.level;
                end
            endcase
        end else if (s.pcnt != 2'h0) begin
            if (tick) begin
                next_s.pcnt = s.pcnt - 2'h1;
                if (s.pcnt == 2'h1) begin
                    next_s.level = (pol == tagpio_pkg::TAGPIO_POL_FALL);
                end
            end
        end else if (pol == tagpio_pkg::TAGPIO_POL_RISE) begin
            next_s.level = 1'b0;
        end else if (pol == tagpio_pkg::TAGPIO_POL_FALL) begin
            next_s.level = 1'b1;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s <= '0;
        end else if (ce) begin
            s <= next_s;
        end
    end

    assign level = s.level;

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    rise_pulse_a: assert property (ce && event_in &&
        pol == tagpio_pkg::TAGPIO_POL_RISE |=> level && s.pcnt == 2'h2)
        else $error("rising pulse did not start");
    fall_pulse_a: assert property (ce && event_in &&
        pol == tagpio_pkg::TAGPIO_POL_FALL |=> !level && s.pcnt == 2'h2)
        else $error("falling pulse did not start");
    pulse_end_a: assert property (ce && !event_in && s.pcnt == 2'h1 &&
        tick |=> level == (pol == tagpio_pkg::TAGPIO_POL_FALL))
        else $error("pulse did not end after two ticks");
    toggle_edge_a: assert property (ce && event_in &&
        pol == tagpio_pkg::TAGPIO_POL_BOTH |=> level != $past(level))
        else $error("toggle event did not invert the output");
endmodule

// ---- tagpio_top.sv ----
// time-aware pin unit: two channels that timestamp pin edges or make
// edges at programmed timer values, reached over an AHB-Lite slave.
// assumes timer counts and their tick strobes arrive already in hclk domain.
`timescale 1ns/1ps
// Summary of operation
// - two independent channels, each set to input capture or output events
// - a channel reaches its pad only while the native function is selected
// - input event copies the running timer count into the capture register
// - event polarity picks rising, falling or both edges as input events
// - a new input level counts only after holding three timer ticks
// - output event fires when the timer count equals the compare time
// - periodic mode re-arms the compare by the interval after every match
// - event polarity picks rising pulse, falling pulse or toggle on output
// - rising pulse type rests low and each event drives it high briefly
// - falling pulse type rests high and each event drives it low briefly
// - output pulses last exactly two timer ticks before returning to rest
// - toggle type inverts the present output level once per event
// - every output event also captures the timer count
// - event counter increments on each input or output event
// - reading the capture low word freezes capture high word and count
// - any enabled channel keeps the oscillator on and blocks deep idle
// - source select 0 picks the local timer, others alternate time bases
module tagpio_top #(
    parameter int unsigned TW = 64,
    parameter int unsigned CW = 32
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic ce,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    input wire logic [TW-1:0] always_running_timer_count,
    input wire logic always_running_timer_tick,
    input wire logic [TW-1:0] alternate_time_base_count0,
    input wire logic [TW-1:0] alternate_time_base_count1,
    input wire logic [TW-1:0] alternate_time_base_count2,
    input wire logic [2:0] alternate_time_base_tick,
    input wire logic [1:0] timed_pin_native_function,
    input wire logic [1:0] pin_in,
    output logic [1:0] pin_out,
    output logic [1:0] pin_oe,
    input wire logic deep_idle_request,
    output logic deep_idle_sleep_indication,
    output logic xtal_keep_running
);
    localparam int unsigned N = tagpio_pkg::CH_NUM;
    localparam int unsigned CTW = tagpio_pkg::CTRL_W;

    typedef struct packed {
        logic ready;
        logic [31:0] rdata;
        logic rd_pend;
        logic wr_pend;
        logic [6:0] addr;
        logic [N-1:0][CTW-1:0] ctrl;
        logic [N-1:0][TW-1:0] cmp;
        logic [N-1:0][TW-1:0] piv;
        logic [N-1:0] armed;
        logic [N-1:0][TW-1:0] next_match;
        logic [N-1:0][TW-1:0] tcv;
        logic [N-1:0][CW-1:0] ecc;
        logic [N-1:0][31:0] hold_hi;
        logic [N-1:0][CW-1:0] hold_ecc;
        logic [N-1:0] pin_out;
        logic [N-1:0] pin_oe;
        logic [N-1:0] drive;
        logic sleep;
        logic xtal;
    } tagpio_top_st_t;

    tagpio_top_st_t s;
    tagpio_top_st_t next_s;

    logic accept;
    logic [N-1:0] en;
    logic [N-1:0] out_mode;
    logic [N-1:0] periodic;
    logic [N-1:0][1:0] pol;
    logic [N-1:0] tick_sel;
    logic [N-1:0][TW-1:0] now_sel;
    logic [N-1:0] in_rise;
    logic [N-1:0] in_fall;
    logic [N-1:0] in_ev;
    logic [N-1:0] out_ev;
    logic [N-1:0] rearm;
    logic [N-1:0] freeze;
    logic [N-1:0] level;

    function automatic logic sel_tick(input logic [1:0] src);
        case (src)
            tagpio_pkg::SRC_ART: sel_tick = always_running_timer_tick;
            2'b01: sel_tick = alternate_time_base_tick[0];
            2'b10: sel_tick = alternate_time_base_tick[1];
            default: sel_tick = alternate_time_base_tick[2];
        endcase
    endfunction

    function automatic logic [TW-1:0] sel_now(input logic [1:0] src);
        case (src)
            tagpio_pkg::SRC_ART: sel_now = always_running_timer_count;
            2'b01: sel_now = alternate_time_base_count0;
            2'b10: sel_now = alternate_time_base_count1;
            default: sel_now = alternate_time_base_count2;
        endcase
    endfunction

    assign accept = ce && hsel && htrans[1] && hready;

    // a process, so that timer inputs read inside the selectors wake it
    always_comb begin
        for (int i = 0; i < N; i++) begin
            tick_sel[i] = sel_tick(s.ctrl[i][tagpio_pkg::CTRL_SRC_LSB +: 2]);
            now_sel[i] = sel_now(s.ctrl[i][tagpio_pkg::CTRL_SRC_LSB +: 2]);
        end
    end

    genvar g;
    generate
        for (g = 0; g < N; g++) begin : gen_ch
            assign en[g] = s.ctrl[g][tagpio_pkg::CTRL_EN];
            assign out_mode[g] = s.ctrl[g][tagpio_pkg::CTRL_OUT];
            assign periodic[g] = s.ctrl[g][tagpio_pkg::CTRL_PER];
            assign pol[g] = s.ctrl[g][tagpio_pkg::CTRL_POL_LSB +: 2];
            // the pad gives this channel nothing unless muxed to it
            tagpio_qual u_qual (
                .hclk(hclk),
                .hresetn(hresetn),
                .ce(ce),
                .tick(tick_sel[g]),
                .pin(pin_in[g] & timed_pin_native_function[g]),
                .rise(in_rise[g]),
                .fall(in_fall[g])
            );
            assign in_ev[g] = en[g] && !out_mode[g] &&
                ((in_rise[g] && (pol[g] == tagpio_pkg::TAGPIO_POL_RISE ||
                  pol[g] == tagpio_pkg::TAGPIO_POL_BOTH)) ||
                 (in_fall[g] && (pol[g] == tagpio_pkg::TAGPIO_POL_FALL ||
                  pol[g] == tagpio_pkg::TAGPIO_POL_BOTH)));
            assign out_ev[g] = en[g] && out_mode[g] && s.armed[g] &&
                tick_sel[g] && now_sel[g] == s.next_match[g];
            tagpio_outgen u_outgen (
                .hclk(hclk),
                .hresetn(hresetn),
                .ce(ce),
                .tick(tick_sel[g]),
                .polarity(pol[g]),
                .event_in(out_ev[g]),
                .level(level[g])
            );
        end
    endgenerate

    always_comb begin
        logic [5:0] ofs;
        int unsigned ch;
        ofs = s.addr[5:0];
        ch = 32'(s.addr[tagpio_pkg::CH_SEL_BIT]);
        next_s = s;
        rearm = '0;
        freeze = '0;
        // write data phase; compare high word write arms the match
        if (s.wr_pend) begin
            next_s.wr_pend = 1'b0;
            case (ofs)
                tagpio_pkg::OFS_CTRL: next_s.ctrl[ch] = hwdata[CTW-1:0];
                tagpio_pkg::OFS_CMP_LO: next_s.cmp[ch][31:0] = hwdata;
                tagpio_pkg::OFS_CMP_HI: begin
                    next_s.cmp[ch][TW-1:32] = hwdata[TW-33:0];
                    rearm[ch] = 1'b1;
                end
                tagpio_pkg::OFS_PIV_LO: next_s.piv[ch][31:0] = hwdata;
                tagpio_pkg::OFS_PIV_HI: next_s.piv[ch][TW-1:32] = hwdata[TW-33:0];
                default: next_s.wr_pend = 1'b0;
            endcase
        end
        // read data phase: one wait state, then data with hreadyout
        if (s.rd_pend) begin
            next_s.rd_pend = 1'b0;
            next_s.ready = 1'b1;
            case (ofs)
                tagpio_pkg::OFS_CTRL:
                    next_s.rdata = {{(32 - CTW){1'b0}}, s.ctrl[ch]};
                tagpio_pkg::OFS_CMP_LO: next_s.rdata = s.cmp[ch][31:0];
                tagpio_pkg::OFS_CMP_HI: next_s.rdata = s.cmp[ch][TW-1:32];
                tagpio_pkg::OFS_PIV_LO: next_s.rdata = s.piv[ch][31:0];
                tagpio_pkg::OFS_PIV_HI: next_s.rdata = s.piv[ch][TW-1:32];
                tagpio_pkg::OFS_TCV_LO: begin
                    next_s.rdata = s.tcv[ch][31:0];
                    freeze[ch] = 1'b1;
                end
                tagpio_pkg::OFS_TCV_HI: next_s.rdata = s.hold_hi[ch];
                tagpio_pkg::OFS_ECC: next_s.rdata = s.hold_ecc[ch];
                default: next_s.rdata = 32'h0000_0000;
            endcase
        end
        if (accept) begin
            next_s.addr = haddr[6:0];
            next_s.wr_pend = hwrite;
            next_s.rd_pend = ~hwrite;
            next_s.ready = hwrite;
        end
        for (int i = 0; i < N; i++) begin
            if (rearm[i]) begin
                next_s.armed[i] = 1'b1;
                next_s.next_match[i] = next_s.cmp[i];
            end else if (out_ev[i]) begin
                if (periodic[i]) begin
                    next_s.next_match[i] = s.next_match[i] + s.piv[i];
                end else begin
                    next_s.armed[i] = 1'b0;
                end
            end
            if (in_ev[i] || out_ev[i]) begin
                next_s.tcv[i] = now_sel[i];
                next_s.ecc[i] = s.ecc[i] + CW'(1);
            end
            // snapshot taken from values before any same-cycle event
            if (freeze[i]) begin
                next_s.hold_hi[i] = s.tcv[i][TW-1:32];
                next_s.hold_ecc[i] = s.ecc[i];
            end
            // pad enable lags a cycle so the stale rest level never shows
            next_s.drive[i] = en[i] && out_mode[i] &&
                timed_pin_native_function[i];
            next_s.pin_oe[i] = next_s.drive[i] && s.drive[i];
            next_s.pin_out[i] = next_s.pin_oe[i] & level[i];
        end
        next_s.xtal = |en;
        next_s.sleep = deep_idle_request && !(|en);
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s <= '0;
            s.ready <= 1'b1;
            s.ctrl <= {N{tagpio_pkg::CTRL_RESET}};
        end else if (ce) begin
            s <= next_s;
        end
    end

    assign hreadyout = s.ready;
    assign hrdata = s.rdata;
    assign hresp = 1'b0;
    assign pin_out = s.pin_out;
    assign pin_oe = s.pin_oe;
    assign deep_idle_sleep_indication = s.sleep;
    assign xtal_keep_running = s.xtal;

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    capture_in_a: assert property (ce && in_ev[0] |=>
        s.tcv[0] == $past(now_sel[0]))
        else $error("input event did not capture the timer");
    pol_filter_a: assert property (ce && in_rise[0] && !out_mode[0] &&
        pol[0] == tagpio_pkg::TAGPIO_POL_FALL |=> $stable(s.ecc[0]))
        else $error("rising edge counted in falling-only mode");
    match_fire_a: assert property (ce && en[1] && out_mode[1] &&
        s.armed[1] && tick_sel[1] && now_sel[1] == s.next_match[1] &&
        !periodic[1] && !rearm[1] |=> !s.armed[1] &&
        s.ecc[1] == $past(s.ecc[1]) + CW'(1))
        else $error("compare match did not fire once");
    periodic_step_a: assert property (ce && out_ev[1] && periodic[1] &&
        !rearm[1] |=> s.armed[1] &&
        s.next_match[1] == $past(s.next_match[1]) + $past(s.piv[1]))
        else $error("periodic compare not advanced by the interval");
    out_capture_a: assert property (ce && out_ev[1] |=>
        s.tcv[1] == $past(now_sel[1]))
        else $error("output event did not capture the timer");
    count_up_a: assert property (ce && in_ev[0] |=>
        s.ecc[0] == $past(s.ecc[0]) + CW'(1))
        else $error("event counter did not step by one");
    freeze_pair_a: assert property (ce && freeze[0] |=>
        s.hold_ecc[0] == $past(s.ecc[0]) &&
        s.hold_hi[0] == $past(s.tcv[0][TW-1:32]))
        else $error("capture and count not frozen together");
    sleep_block_a: assert property (ce && (|en) |=>
        !deep_idle_sleep_indication && xtal_keep_running)
        else $error("deep idle indicated while a channel is enabled");
    pad_gate_a: assert property (ce && !timed_pin_native_function[0] |=>
        !pin_oe[0] && !pin_out[0])
        else $error("pin driven without native function selected");
    src_local_a: assert property (s.ctrl[0][tagpio_pkg::CTRL_SRC_LSB +: 2] ==
        tagpio_pkg::SRC_ART |-> now_sel[0] == always_running_timer_count)
        else $error("local timer not selected for source zero");
endmodule

// ---- tagpio_sync_peer.sv ----
// far-side partner: a sync source on one pin input, and a sink that
// times the pulses or counts the edges on one pin output.
// assumes tick is the one-cycle timer strobe in the hclk domain.
`timescale 1ns/1ps
module tagpio_sync_peer (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic tick,
    input wire logic go,
    input wire logic [3:0] hold_ticks,
    output logic pin,
    output logic busy,
    input wire logic drv,
    input wire logic oe,
    input wire logic rest,
    input wire logic toggle_mode,
    output logic [7:0] run_len,
    output logic run_done,
    output int events
);
    logic [3:0] left;
    logic [7:0] run;
    logic prev;
    assign busy = left != 4'h0;
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pin <= 1'b0;
            left <= 4'h0;
            run <= 8'h00;
            run_len <= 8'h00;
            run_done <= 1'b0;
            prev <= 1'b0;
            events <= 0;
        end else begin
            run_done <= 1'b0;
            prev <= drv & oe;
            // a go while busy is ignored, so each level holds its time
            if (go && !busy) begin
                pin <= ~pin;
                left <= hold_ticks;
            end else if (tick && busy) begin
                left <= left - 4'h1;
            end
            // a run cut short by a disable is dropped, not reported
            if (!oe) begin
                run <= 8'h00;
            end else if (drv !== rest) begin
                run <= run + 8'h01;
            end else if (run != 8'h00) begin
                run_len <= run;
                run_done <= 1'b1;
                run <= 8'h00;
            end
            if (toggle_mode ? (oe && drv !== prev) : run_done) begin
                events <= events + 1;
            end
        end
    end
endmodule

// ---- tb_top.sv ----
// self-checking bench: timers, AHB-Lite master, sync partner, integer
// expectations. assumes channel 0 faces the source, channel 1 the sink.
`timescale 1ns/1ps
module tb_top;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, seed = 32'h00006FA8;
    logic [1:0] htrans = 2'h0, div = 2'h0, mux = 2'h0;
    logic [63:0] always_running_timer = 64'h0, alt = 64'h0;
    logic hwrite = 1'b0, art_tick = 1'b0, alt_tick = 1'b0;
    logic idle_req = 1'b0, go = 1'b0, rest = 1'b0, tog = 1'b0;
    logic [3:0] hold = 4'h4;
    logic [31:0] hrdata;
    logic [7:0] run_len;
    logic [1:0] pin_out, pin_oe;
    logic hreadyout, src_pin, busy, run_done, idle_ind, xtal, hresp;
    int events;
    int failures = 0;
    int check_count = 0;
    int exp_w = 6;
    always #10 hclk = ~hclk;
    // local timer ticks every third cycle, alternate bases every second
    always @(posedge hclk) begin
        div <= (div == 2'h2) ? 2'h0 : div + 2'h1;
        art_tick <= div == 2'h2;
        alt_tick <= ~alt_tick;
        always_running_timer <= always_running_timer + {63'h0, art_tick};
        alt <= alt + {63'h0, alt_tick};
    end
    tagpio_top dut_u (
        .hclk(hclk), .hresetn(hresetn), .ce(1'b1), .hsel(1'b1),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
        .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
        .hrdata(hrdata), .hresp(hresp), .always_running_timer_count(always_running_timer),
        .always_running_timer_tick(art_tick),
        .alternate_time_base_count0(alt),
        .alternate_time_base_count1(alt + 64'h3E8),
        .alternate_time_base_count2(alt + 64'h7D0),
        .alternate_time_base_tick({3{alt_tick}}),
        .timed_pin_native_function(mux), .pin_in({1'b0, src_pin}),
        .pin_out(pin_out), .pin_oe(pin_oe), .deep_idle_request(idle_req),
        .deep_idle_sleep_indication(idle_ind), .xtal_keep_running(xtal));
    tagpio_sync_peer peer_u (
        .hclk(hclk), .hresetn(hresetn), .tick(art_tick), .go(go),
        .hold_ticks(hold), .pin(src_pin), .busy(busy), .drv(pin_out[1]),
        .oe(pin_oe[1]), .rest(rest), .toggle_mode(tog),
        .run_len(run_len), .run_done(run_done), .events(events));
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    function automatic logic [31:0] ad(input int ch, input logic [5:0] o);
        return (32'(ch) << tagpio_pkg::CH_SEL_BIT) | {26'h0, o};
    endfunction
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", check_count, failures);
        if (failures == 0 && check_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] x,
                       input string what);
        check_count++;
        if (g !== x) begin
            failures++;
            $display("unexpected at %0t: %s got %h", $time, what, g);
        end
    endtask
    // one single transfer; the data phase ends when hready is seen high
    task automatic bus(input logic [31:0] a, input logic w,
                       input logic [31:0] wd, output logic [31:0] rd);
        int n;
        @(posedge hclk);
        haddr <= a;
        hwrite <= w;
        htrans <= 2'h2;
        n = 0;
        do begin
            @(negedge hclk);
            n++;
        end while (hreadyout !== 1'b1 && n < 64);
        @(posedge hclk);
        htrans <= 2'h0;
        hwdata <= wd;
        do begin
            @(negedge hclk);
            n++;
        end while (hreadyout !== 1'b1 && n < 64);
        rd = hrdata;
        @(posedge hclk);
        if (n >= 64) begin
            chk(32'h0, 32'h1, "bus timeout");
            give_verdict();
        end
    endtask
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        logic [31:0] x;
        bus(a, 1'b1, d, x);
    endtask
    task automatic rd(input logic [31:0] a, output logic [31:0] d);
        bus(a, 1'b0, 32'h0, d);
    endtask
    task automatic wait_ev(input int target);
        int n;
        n = 0;
        while (events < target && n < 3000) begin
            @(posedge hclk);
            n++;
        end
        if (n >= 3000) begin
            chk(32'h0, 32'h1, "event timeout");
            give_verdict();
        end
    endtask
    always @(posedge hclk) begin
        if (run_done && !tog) begin
            chk({24'h0, run_len}, 32'(exp_w), "pulse width");
        end
    end
    initial begin
        logic [31:0] v, t, e, e0, cmp, iv, c0;
        int x;
        repeat (8) @(posedge hclk);
        hresetn <= 1'b1;
        for (int ch = 0; ch < 2; ch++) begin
            rd(ad(ch, tagpio_pkg::OFS_CTRL), v);
            chk(v, {25'h0, tagpio_pkg::CTRL_RESET}, "ctrl reset");
        end
        rd(32'h20, v);
        chk(v, 32'h0, "unmapped");
        chk({31'h0, hresp}, 32'h0, "okay response");
        wr(ad(0, tagpio_pkg::OFS_ECC), 32'hA5A5A5A5);
        rd(ad(0, tagpio_pkg::OFS_TCV_LO), v);
        rd(ad(0, tagpio_pkg::OFS_ECC), v);
        chk(v, 32'h0, "count read only");
        idle_req <= 1'b1;
        repeat (3) @(negedge hclk);
        chk({31'h0, idle_ind}, 32'h1, "idle allowed");
        $display("test reset done");
        mux <= 2'h1;
        for (int p = 0; p < 3; p++) begin
            wr(ad(0, tagpio_pkg::OFS_CTRL), 32'(p << 2) | 32'h1);
            rd(ad(0, tagpio_pkg::OFS_TCV_LO), v);
            rd(ad(0, tagpio_pkg::OFS_ECC), e0);
            x = 0;
            // third level is too short to count, fourth undoes it
            for (int k = 0; k < 4; k++) begin
                @(posedge hclk);
                hold <= (k == 2) ? 4'h1 : 4'h4;
                go <= 1'b1;
                @(posedge hclk);
                go <= 1'b0;
                repeat (k == 2 ? 4 : 14) @(posedge hclk);
                if (k < 2 && (p == 2 || p == k)) begin
                    x++;
                    c0 = always_running_timer[31:0] - 32'h4;
                end
            end
            rd(ad(0, tagpio_pkg::OFS_TCV_LO), t);
            rd(ad(0, tagpio_pkg::OFS_ECC), e);
            chk(e - e0, 32'(x), "input count");
            t = t - c0;
            chk(32'(t >= 32'h2 && t <= 32'h3), 32'h1, "stamp");
        end
        chk({30'h0, xtal, idle_ind}, 32'h2, "osc kept");
        wr(ad(0, tagpio_pkg::OFS_CTRL), 32'h0);
        $display("test input done");
        wr(ad(1, tagpio_pkg::OFS_CTRL), 32'h3);
        repeat (3) @(negedge hclk);
        chk({31'h0, pin_oe[1]}, 32'h0, "pad not muxed");
        mux <= 2'h3;
        repeat (3) @(negedge hclk);
        chk({31'h0, pin_oe[1]}, 32'h1, "pad muxed");
        for (int p = 0; p < 3; p++) begin
            wr(ad(1, tagpio_pkg::OFS_CTRL), 32'h0);
            tog <= p == 2;
            rest <= p == 1;
            exp_w = (p == 0) ? 6 : 4;
            iv = 32'h3 + (xs() & 32'h3);
            rd(ad(1, tagpio_pkg::OFS_TCV_LO), v);
            rd(ad(1, tagpio_pkg::OFS_ECC), e0);
            cmp = (p == 0) ? always_running_timer[31:0] : alt[31:0] + 32'(p - 1) * 32'h3E8;
            cmp = cmp + 32'h14 + (xs() & 32'h7);
            wr(ad(1, tagpio_pkg::OFS_PIV_LO), iv);
            wr(ad(1, tagpio_pkg::OFS_PIV_HI), 32'h0);
            wr(ad(1, tagpio_pkg::OFS_CMP_LO), cmp);
            wr(ad(1, tagpio_pkg::OFS_CMP_HI), 32'h0);
            // first pass is one-shot, the others periodic
            wr(ad(1, tagpio_pkg::OFS_CTRL),
               32'(p * 36) | (p > 0 ? 32'h13 : 32'h3));
            repeat (3) @(negedge hclk);
            if (p != 2) begin
                chk({31'h0, pin_out[1]}, 32'(p), "rest level");
            end
            wait_ev(events + (p > 0 ? 2 : 1));
            rd(ad(1, tagpio_pkg::OFS_TCV_LO), t);
            if (p > 0) begin
                wait_ev(events + 2);
            end
            rd(ad(1, tagpio_pkg::OFS_TCV_HI), v);
            rd(ad(1, tagpio_pkg::OFS_ECC), e);
            chk(v, 32'h0, "stamp high");
            chk(t, cmp + (e - e0 - 32'h1) * iv, "periodic");
        end
        wr(ad(1, tagpio_pkg::OFS_CTRL), 32'h0);
        repeat (3) @(negedge hclk);
        chk({30'h0, xtal, idle_ind}, 32'h1, "idle again");
        $display("test output done");
        give_verdict();
    end
endmodule
